//--- src/fcs_sequencer.sv
// Flash command sequencer: unlock decode, busy timing, toggle polling,
// identification mode, read protection and an AXI4-Lite register slave.
// Assumes the CPU port and AXI share clk_i; mode pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer #(
  parameter int ARRAY_BYTES = 16384,
  parameter int TW = 20,
  parameter int CHIP_ERASE_CYC = fcs_pkg::CHIP_ERASE_CYC,
  parameter int SECTOR_ERASE_CYC = fcs_pkg::SECTOR_ERASE_CYC,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] MACRO_CODE = 8'hC3, // Arbitrary value
  parameter logic [7:0] SIZE_CODE = fcs_pkg::SIZE_CODE_16K
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // CPU flash port
  input wire fcs_pkg::fcs_cpu_req_s cpu_req_i,
  output logic [8:0] cpu_rsp_o,
  // Mode pins and serial loader
  input wire logic parallel_mode_i,
  input wire logic ram_loader_mode_i,
  input wire logic serial_write_cmd_i,
  input wire logic serial_loader_cmd_i,
  output logic serial_write_allow_o,
  output logic serial_loader_allow_o,
  output logic parallel_read_blocked_o,
  output logic watchdog_stop_o,
  output logic busy_o,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import fcs_pkg::*;

  localparam int AW = $clog2(ARRAY_BYTES);
  localparam logic [16:0] ARRAY_BASE = 17'(32'h0001_0000 - ARRAY_BYTES);

  function automatic logic in_array(input logic [15:0] a);
    return {1'b0, a} >= ARRAY_BASE;
  endfunction

  function automatic logic hit(input fcs_cpu_req_s r, input logic [11:0] ca,
                               input logic [7:0] cd);
    return (r.addr[11:0] == ca) && (r.wdata == cd);
  endfunction

  fcs_seq_e state_reg, state_next;
  fcs_op_e op_reg, start_op;
  logic [3:0] cmd_field_reg;
  logic id_mode_reg, protect_reg, toggle_reg;
  logic id_set, id_clr;
  logic sweep_active_reg;
  logic [AW-1:0] sweep_idx_reg, sweep_last_reg;
  logic rvalid_reg, use_mem_reg;
  logic [7:0] alt_reg, poll_byte, id_byte, mem_rdata, mem_wdata;
  logic [AW-1:0] mem_addr;
  logic mem_we;
  logic [TW-1:0] timer_count;
  logic timer_expired;
  logic [1:0] mode_meta_reg, mode_sync_reg;
  logic wr, rd, cmd_ok, seq_wr, busy, op_done, par_mode, loader_mode;

  assign wr = cpu_req_i.valid & cpu_req_i.we;
  assign rd = cpu_req_i.valid & ~cpu_req_i.we;
  assign cmd_ok = (cmd_field_reg == CMD_ENABLE);
  assign busy = (state_reg == ST_BUSY);
  // Array-resident code and busy periods never reach the decoder
  assign seq_wr = wr & ~cpu_req_i.from_array & cmd_ok & ~busy;
  assign op_done = busy & timer_expired & ~sweep_active_reg;

  // Mode pins pass through two synchronizer flops before use
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_meta_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
    end else begin
      mode_meta_reg <= {ram_loader_mode_i, parallel_mode_i};
      mode_sync_reg <= mode_meta_reg;
    end
  end
  assign par_mode = mode_sync_reg[0];
  assign loader_mode = mode_sync_reg[1];

  // Sequence decoder
  always_comb begin
    state_next = state_reg;
    start_op = OP_NONE;
    id_set = 1'b0;
    id_clr = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (seq_wr) begin
          if (hit(cpu_req_i, UNLOCK_A1, UNLOCK_D1)) begin
            state_next = ST_UNLOCK1;
          end else if (cpu_req_i.wdata == CMD_ID_EXIT) begin
            id_clr = 1'b1;
          end
        end
      end
      ST_UNLOCK1: begin
        if (seq_wr) begin
          state_next = hit(cpu_req_i, UNLOCK_A2, UNLOCK_D2) ? ST_UNLOCK2 : ST_IDLE;
        end
      end
      ST_UNLOCK2: begin
        if (seq_wr) begin
          state_next = ST_IDLE;
          if (cpu_req_i.addr[11:0] == UNLOCK_A1) begin
            case (cpu_req_i.wdata)
              CMD_PROGRAM: state_next = ST_PROG_ADDR;
              CMD_ERASE: state_next = ST_ERASE1;
              CMD_ID_ENTRY: id_set = 1'b1;
              CMD_ID_EXIT: id_clr = 1'b1;
              CMD_PROTECT: state_next = ST_PROT_ADDR;
              default: state_next = ST_IDLE;
            endcase
          end
        end
      end
      ST_PROG_ADDR: begin
        if (seq_wr) begin
          state_next = ST_IDLE;
          if (in_array(cpu_req_i.addr)) begin
            start_op = OP_PROGRAM;
            state_next = ST_BUSY;
          end
        end
      end
      ST_ERASE1: begin
        if (seq_wr) begin
          state_next = hit(cpu_req_i, UNLOCK_A1, UNLOCK_D1) ? ST_ERASE2 : ST_IDLE;
        end
      end
      ST_ERASE2: begin
        if (seq_wr) begin
          state_next = hit(cpu_req_i, UNLOCK_A2, UNLOCK_D2) ? ST_ERASE3 : ST_IDLE;
        end
      end
      ST_ERASE3: begin
        if (seq_wr) begin
          state_next = ST_IDLE;
          if (hit(cpu_req_i, UNLOCK_A1, CMD_CHIP)) begin
            start_op = OP_CHIP;
            state_next = ST_BUSY;
          end else if (cpu_req_i.wdata == CMD_SECTOR && in_array(cpu_req_i.addr)) begin
            start_op = OP_SECTOR;
            state_next = ST_BUSY;
          end
        end
      end
      ST_PROT_ADDR: begin
        if (seq_wr) begin
          state_next = ST_IDLE;
          if (cpu_req_i.addr == PROTECT_ADDR && cpu_req_i.wdata == PROTECT_DATA) begin
            start_op = OP_PROTECT;
            state_next = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (op_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
    end else begin
      state_reg <= state_next;
      if (start_op != OP_NONE) begin
        op_reg <= start_op;
      end else if (op_done) begin
        op_reg <= OP_NONE;
      end
    end
  end

  // Operation duration
  always_comb begin
    case (start_op)
      OP_PROGRAM: timer_count = TW'(PROGRAM_CYC);
      OP_PROTECT: timer_count = TW'(PROTECT_CYC);
      OP_CHIP: timer_count = TW'(CHIP_ERASE_CYC);
      OP_SECTOR: timer_count = TW'(SECTOR_ERASE_CYC);
      default: timer_count = '0;
    endcase
  end

  fcs_busy_timer #(.TW(TW)) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(start_op != OP_NONE),
    .count_i(timer_count),
    .expired_o(timer_expired)
  );

  // Erase sweep writes FFH one byte a cycle; busy lasts until both it and timer end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sweep_active_reg <= 1'b0;
      sweep_idx_reg <= '0;
      sweep_last_reg <= '0;
    end else if (start_op == OP_CHIP) begin
      sweep_active_reg <= 1'b1;
      sweep_idx_reg <= '0;
      sweep_last_reg <= '1;
    end else if (start_op == OP_SECTOR) begin
      sweep_active_reg <= 1'b1;
      sweep_idx_reg <= {cpu_req_i.addr[AW-1:SECTOR_AW], {SECTOR_AW{1'b0}}};
      sweep_last_reg <= {cpu_req_i.addr[AW-1:SECTOR_AW], {SECTOR_AW{1'b1}}};
    end else if (sweep_active_reg) begin
      if (sweep_idx_reg == sweep_last_reg) begin
        sweep_active_reg <= 1'b0;
      end else begin
        sweep_idx_reg <= sweep_idx_reg + AW'(1);
      end
    end
  end

  assign mem_we = sweep_active_reg | (start_op == OP_PROGRAM);
  assign mem_addr = sweep_active_reg ? sweep_idx_reg : cpu_req_i.addr[AW-1:0];
  assign mem_wdata = sweep_active_reg ? ERASED_BYTE : cpu_req_i.wdata;

  fcs_array_mem #(.AW(AW)) u_mem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Mode and protection flags; protection is held until reset or the end of a chip erase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      id_mode_reg <= 1'b0;
      protect_reg <= 1'b0;
    end else begin
      if (id_set) begin
        id_mode_reg <= 1'b1;
      end else if (id_clr) begin
        id_mode_reg <= 1'b0;
      end
      if (op_done && op_reg == OP_PROTECT) begin
        protect_reg <= 1'b1;
      end else if (op_done && op_reg == OP_CHIP) begin
        protect_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      toggle_reg <= 1'b0;
    end else if (start_op != OP_NONE) begin
      toggle_reg <= 1'b1;
    end else if (rd && busy) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  always_comb begin
    poll_byte = 8'h00;
    poll_byte[TOGGLE_BIT] = toggle_reg;
  end

  always_comb begin
    if (cpu_req_i.addr == ID_MAKER_ADDR) begin
      id_byte = MAKER_CODE;
    end else if (cpu_req_i.addr == ID_MACRO_ADDR) begin
      id_byte = MACRO_CODE;
    end else if (cpu_req_i.addr == ID_SIZE_ADDR) begin
      id_byte = SIZE_CODE;
    end else if (cpu_req_i.addr == PROTECT_ADDR) begin
      id_byte = protect_reg ? PROT_ON_BYTE : PROT_OFF_BYTE;
    end else begin
      id_byte = 8'h00;
    end
  end

  // Read answer: one cycle after the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rvalid_reg <= 1'b0;
      use_mem_reg <= 1'b0;
      alt_reg <= 8'h00;
    end else begin
      rvalid_reg <= rd;
      use_mem_reg <= 1'b0;
      if (rd) begin
        if (busy) begin
          alt_reg <= poll_byte;
        end else if (id_mode_reg) begin
          alt_reg <= id_byte;
        end else if (par_mode && protect_reg) begin
          alt_reg <= 8'h00;
        end else if (in_array(cpu_req_i.addr)) begin
          use_mem_reg <= 1'b1;
        end else begin
          alt_reg <= 8'h00;
        end
      end
    end
  end

  assign cpu_rsp_o = {rvalid_reg, use_mem_reg ? mem_rdata : alt_reg};

  assign serial_write_allow_o = serial_write_cmd_i & ~protect_reg;
  assign serial_loader_allow_o = serial_loader_cmd_i & ~protect_reg;
  assign parallel_read_blocked_o = par_mode & protect_reg;
  assign watchdog_stop_o = loader_mode;
  assign busy_o = busy;

  // AXI4-Lite slave: address and data may arrive in either order
  logic aw_held_reg, w_held_reg, bvalid_reg, arvalid_reg;
  logic [31:0] awaddr_reg, wdata_reg, rdata_reg, status_word;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic do_write;

  assign s_axi_awready_o = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready_o = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = ~arvalid_reg;
  assign s_axi_rvalid_o = arvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        if (awaddr_reg == REG_CTRL_OFS || awaddr_reg == REG_STATUS_OFS) begin
          bresp_reg <= RESP_OKAY;
        end else begin
          bresp_reg <= RESP_DECERR;
        end
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_field_reg <= CMD_DISABLE;
    end else if (do_write && awaddr_reg == REG_CTRL_OFS && wstrb_reg[0]) begin
      cmd_field_reg <= wdata_reg[CMD_EN_LSB +: 4];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_BUSY_BIT] = busy;
    status_word[ST_PROT_BIT] = protect_reg;
    status_word[ST_ID_BIT] = id_mode_reg;
    status_word[ST_CMDEN_BIT] = cmd_ok;
    status_word[ST_OP_LSB +: 5] = op_reg;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      arvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      arvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      if (s_axi_araddr_i == REG_CTRL_OFS) begin
        rdata_reg <= 32'h0000_0000;
        rdata_reg[CMD_EN_LSB +: 4] <= cmd_field_reg;
      end else if (s_axi_araddr_i == REG_STATUS_OFS) begin
        rdata_reg <= status_word;
      end else begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= RESP_DECERR;
      end
    end else if (arvalid_reg && s_axi_rready_i) begin
      arvalid_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- inc/fcs_pkg.sv
// Constants, types and register map of the flash command sequencer.
// Assumes a 20 MHz system clock and a 16-bit CPU address space.
package fcs_pkg;
  // Unlock and command codes
  localparam logic [11:0] UNLOCK_A1 = 12'h555;
  localparam logic [11:0] UNLOCK_A2 = 12'hAAA;
  localparam logic [7:0] UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
  localparam logic [7:0] CMD_PROTECT = 8'hA5;
  localparam logic [7:0] PROTECT_DATA = 8'h00;
  localparam logic [15:0] PROTECT_ADDR = 16'hFF7F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int SECTOR_AW = 12;
  localparam int TOGGLE_BIT = 6;
  // Identification mode
  localparam logic [15:0] ID_MAKER_ADDR = 16'hF000;
  localparam logic [15:0] ID_MACRO_ADDR = 16'hF001;
  localparam logic [15:0] ID_SIZE_ADDR = 16'hF002;
  localparam logic [7:0] SIZE_CODE_60K = 8'h0E;
  localparam logic [7:0] SIZE_CODE_48K = 8'h0B;
  localparam logic [7:0] SIZE_CODE_32K = 8'h07;
  localparam logic [7:0] SIZE_CODE_24K = 8'h05;
  localparam logic [7:0] SIZE_CODE_16K = 8'h03;
  localparam logic [7:0] SIZE_CODE_8K = 8'h01;
  localparam logic [7:0] PROT_OFF_BYTE = 8'hFF;
  localparam logic [7:0] PROT_ON_BYTE = 8'h00;
  // Command-enable field
  localparam logic [3:0] CMD_ENABLE = 4'h3;
  localparam logic [3:0] CMD_DISABLE = 4'hC;
  localparam int CMD_EN_LSB = 4;
  // Timing
  localparam int CLK_KHZ = 20000;
  localparam int CHIP_ERASE_MS = 30;
  localparam int SECTOR_ERASE_MS = 30;
  localparam int PROGRAM_US = 40;
  localparam int PROTECT_US = 40;
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * CLK_KHZ;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CLK_KHZ;
  localparam int PROGRAM_CYC = PROGRAM_US * CLK_KHZ / 1000;
  localparam int PROTECT_CYC = PROTECT_US * CLK_KHZ / 1000;
  // Register map
  localparam logic [31:0] REG_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS_OFS = 32'h0000_0004;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PROT_BIT = 1;
  localparam int ST_ID_BIT = 2;
  localparam int ST_CMDEN_BIT = 3;
  localparam int ST_OP_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_UNLOCK1 = 9'h002, ST_UNLOCK2 = 9'h004,
    ST_PROG_ADDR = 9'h008, ST_ERASE1 = 9'h010, ST_ERASE2 = 9'h020,
    ST_ERASE3 = 9'h040, ST_PROT_ADDR = 9'h080, ST_BUSY = 9'h100
  } fcs_seq_e;

  typedef enum logic [4:0] {
    OP_NONE = 5'h01, OP_PROGRAM = 5'h02, OP_SECTOR = 5'h04,
    OP_CHIP = 5'h08, OP_PROTECT = 5'h10
  } fcs_op_e;

  typedef struct packed {
    logic valid;
    logic we;
    logic from_array;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fcs_cpu_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fcs_cpu_rsp_s;
endpackage

//--- src/fcs_array_mem.sv
// Flash array storage, one byte wide, single port.
// Assumes the caller never reads and writes in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module fcs_array_mem #(
  parameter int AW = 14
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Access port
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= mem[addr_i];
    end
  end

  assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

//--- src/fcs_busy_timer.sv
// Down counter that times one flash operation.
// Assumes load is only raised while the counter is idle.
`timescale 1ns/1ns
`default_nettype none
module fcs_busy_timer #(
  parameter int TW = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic load_i,
  input wire logic [TW-1:0] count_i,
  output logic expired_o
);
  logic [TW-1:0] count_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_reg <= '0;
    end else if (load_i) begin
      count_reg <= count_i;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - TW'(1);
    end
  end

  assign expired_o = (count_reg == '0);
endmodule
`default_nettype wire

//--- tb/fcs_sequencer_assertions.sv
// Port-level checks for the flash command sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer_assertions (
  // Clock, reset and CPU port
  input wire logic clk_i,
  input wire logic reset_i,
  input wire fcs_pkg::fcs_cpu_req_s cpu_req_i,
  input wire logic [8:0] cpu_rsp_o,
  input wire logic busy_o,
  // Loader pins and AXI answer
  input wire logic serial_write_cmd_i,
  input wire logic serial_write_allow_o,
  input wire logic ram_loader_mode_i,
  input wire logic watchdog_stop_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i
);
  import fcs_pkg::*;
  logic rb_reg;
  logic seen_reg;
  logic last_reg;
  wire logic rd = cpu_req_i.valid & ~cpu_req_i.we;
  always_ff @(posedge clk_i) begin
    rb_reg <= ~reset_i & rd & busy_o;
  end
  // Toggle history restarts with each operation
  always_ff @(posedge clk_i) begin
    if (reset_i || (!busy_o && !rb_reg)) begin
      seen_reg <= 1'b0;
    end else if (rb_reg) begin
      seen_reg <= 1'b1;
      last_reg <= cpu_rsp_o[TOGGLE_BIT];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rsp; rd |=> cpu_rsp_o[8]; endproperty
  a_rsp: assert property (p_rsp) else $error("read answer missing");
  property p_tog; rb_reg && seen_reg |-> cpu_rsp_o[TOGGLE_BIT] != last_reg; endproperty
  a_tog: assert property (p_tog) else $error("toggle bit stuck");
  property p_first; rb_reg && !seen_reg |-> cpu_rsp_o[TOGGLE_BIT]; endproperty
  a_first: assert property (p_first) else $error("first toggle not 1");
  // Only the toggle bit may be set in a busy answer
  property p_hide;
    rb_reg |-> cpu_rsp_o[8] && (cpu_rsp_o[7:0] & ~(8'h01 << TOGGLE_BIT)) == 8'h00;
  endproperty
  a_hide: assert property (p_hide) else $error("array data while busy");
  property p_allow; serial_write_allow_o |-> serial_write_cmd_i; endproperty
  a_allow: assert property (p_allow) else $error("write allowed unasked");
  property p_arr; cpu_req_i.valid && cpu_req_i.we && cpu_req_i.from_array && !busy_o |=> !busy_o;
  endproperty
  a_arr: assert property (p_arr) else $error("array-code write took effect");
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_wdog; ram_loader_mode_i [*5] |-> watchdog_stop_o; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not stopped");
  c_tog: cover property (rb_reg && seen_reg);
  c_wdog: cover property (watchdog_stop_o);
  c_bresp: cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule
bind fcs_sequencer fcs_sequencer_assertions u_chk (.clk_i, .reset_i, .cpu_req_i, .cpu_rsp_o,
  .busy_o, .serial_write_cmd_i, .serial_write_allow_o, .ram_loader_mode_i, .watchdog_stop_o,
  .s_axi_bvalid_o, .s_axi_bready_i);
`default_nettype wire

//--- tb/fcs_cpu_model.sv
// CPU running control code from RAM, driving the flash port.
// Assumes the one-cycle read answer of the sequencer.
`timescale 1ns/1ns
`default_nettype none
module fcs_cpu_model (
  // Clock and flash port
  input wire logic clk_i,
  output var fcs_pkg::fcs_cpu_req_s req_o,
  input wire logic [8:0] rsp_i
);
  import fcs_pkg::*;
  logic interrupt_master_flag = 1'b1;
  initial req_o = '0;
  // Idle bus shows inverted leftovers, never stale values
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic fa);
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b1, fa, a, d};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [15:0] a, output logic [8:0] r);
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b0, 1'b0, a, 8'h00};
    @(posedge clk_i);
    req_o <= '{1'b0, 1'b0, 1'b0, ~a, 8'hFF};
    @(posedge clk_i);
    r = rsp_i;
  endtask
  task automatic seq(input logic [3:0] h, input logic [7:0] c);
    interrupt_master_flag = 1'b0;
    wr({h, UNLOCK_A1}, UNLOCK_D1, 1'b0);
    wr({h, UNLOCK_A2}, UNLOCK_D2, 1'b0);
    wr({h, UNLOCK_A1}, c, 1'b0);
  endtask
  task automatic poll(input logic [15:0] a, output int n);
    logic [8:0] p;
    logic [8:0] q;
    n = 0;
    rd(a, q);
    do begin
      p = q;
      rd(a, q);
      n++;
    end while (p !== q && n < 9000);
  endtask
endmodule
`default_nettype wire

//--- tb/fcs_sequencer_bench.sv
// Self-checking bench for the flash command sequencer.
// Assumes the CPU model and port checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", s, e, g); end end
module fcs_sequencer_bench;
  import fcs_pkg::*;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value
  localparam logic [7:0] MC = 8'hC3; // Arbitrary value
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pm = 0, lm = 0, wc = 0, lc = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic wal, lal, pbl, wdg, busy, awr, wrr, bv, arr, rv;
  logic [1:0] br, rr;
  logic [31:0] awa = '0, wd = '0, ara = '0, rdt;
  fcs_cpu_req_s req;
  logic [8:0] rsp, r;
  logic [33:0] x;
  logic [15:0] a;
  logic [7:0] d;
  logic [15:0] ida [4] = '{ID_MAKER_ADDR, ID_MACRO_ADDR, ID_SIZE_ADDR, PROTECT_ADDR};
  logic [7:0] idv [4] = '{MK, MC, SIZE_CODE_16K, PROT_OFF_BYTE};
  int error_cnt = 0, compares = 0, seed = 32'hB533, n, t;
  always #25 clk_i = ~clk_i;
  fcs_sequencer #(.CHIP_ERASE_CYC(20), .SECTOR_ERASE_CYC(20), .MAKER_CODE(MK), .MACRO_CODE(MC))
    DUT (.clk_i, .reset_i, .cpu_req_i(req), .cpu_rsp_o(rsp), .parallel_mode_i(pm),
    .ram_loader_mode_i(lm), .serial_write_cmd_i(wc), .serial_loader_cmd_i(lc),
    .serial_write_allow_o(wal), .serial_loader_allow_o(lal), .parallel_read_blocked_o(pbl),
    .watchdog_stop_o(wdg), .busy_o(busy), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdt),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre));
  fcs_cpu_model cpu (.clk_i, .req_o(req), .rsp_i(rsp));
  task automatic axw(input logic [31:0] ad, input logic [31:0] dt);
    @(posedge clk_i);
    {awa, wd, awv, wv, bre} <= {ad, dt, 3'b111};
    t = 0;
    while (!bv && t < 99) begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      t++;
    end
    `CHK("bvalid", 1'b1, bv)
    bre <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] ad);
    @(posedge clk_i);
    {ara, arv, rre} <= {ad, 2'b11};
    t = 0;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
      t++;
    end while (!rv && t < 99);
    `CHK("rvalid", 1'b1, rv)
    x = {rr, rdt};
    rre <= 1'b0;
  endtask
  task automatic chip;
    cpu.seq(4'hD, CMD_ERASE);
    cpu.seq(4'hE, CMD_CHIP);
    cpu.poll(16'hC000, n);
    `CHK("poll", 1'b1, n < 9000)
    for (int i = 0; i < 4; i++) begin
      cpu.rd(16'hC000 + 16'(i * 'h1555), r);
      `CHK("erased", {1'b1, ERASED_BYTE}, r)
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    cpu.seq(4'hF, CMD_PROGRAM);
    cpu.wr(16'hC000, 8'h11, 1'b0);
    @(posedge clk_i);
    `CHK("busy", 1'b0, busy)
    axr(REG_STATUS_OFS);
    `CHK("cmd en", 1'b0, x[ST_CMDEN_BIT])
    axr(32'h40);
    `CHK("resp", RESP_DECERR, x[33:32])
    axw(REG_CTRL_OFS, {24'h0, CMD_ENABLE, 4'h0});
    `CHK("bresp", RESP_OKAY, br)
    axr(REG_CTRL_OFS);
    `CHK("ctrl", {RESP_OKAY, 24'h0, CMD_ENABLE, 4'h0}, x)
    lm <= 1'b1;
    chip();
    a = 16'hC000 | 16'($random(seed)) & 16'h3FFC;
    d = 8'($random(seed));
    cpu.seq({2'b11, 2'($random(seed))}, CMD_PROGRAM);
    cpu.wr(a, d, 1'b0);
    cpu.seq(4'hC, CMD_PROGRAM);
    cpu.wr(a | 16'h1, ~d, 1'b0);
    cpu.poll(a, n);
    for (int i = 2; i < 4; i++) begin
      cpu.wr({4'hF, UNLOCK_A1}, UNLOCK_D1, i == 2);
      cpu.wr({4'hF, UNLOCK_A2}, i == 2 ? UNLOCK_D2 : 8'h77, 1'b0);
      cpu.wr({4'hF, UNLOCK_A1}, CMD_PROGRAM, 1'b0);
      cpu.wr(a | 16'(i), 8'h00, 1'b0);
      @(posedge clk_i);
      `CHK("busy", 1'b0, busy)
    end
    cpu.seq(4'hF, CMD_ID_ENTRY);
    for (int i = 0; i < 4; i++) begin
      cpu.rd(ida[i], r);
      `CHK("id", {1'b1, idv[i]}, r)
    end
    cpu.seq(4'hF, CMD_ID_EXIT);
    cpu.rd(a, r);
    `CHK("prog", {1'b1, d}, r)
    for (int i = 1; i < 4; i++) begin
      cpu.rd(a | 16'(i), r);
      `CHK("kept", 9'h1FF, r)
    end
    // Sector erase named by another address inside the same 4 KB sector
    cpu.seq(4'hD, CMD_ERASE);
    cpu.wr({4'hD, UNLOCK_A1}, UNLOCK_D1, 1'b0);
    cpu.wr({4'hD, UNLOCK_A2}, UNLOCK_D2, 1'b0);
    cpu.wr(a ^ 16'h0FFC, CMD_SECTOR, 1'b0);
    cpu.poll(a, n);
    `CHK("poll", 1'b1, n < 9000)
    cpu.rd(a, r);
    `CHK("sector", {1'b1, ERASED_BYTE}, r)
    cpu.seq(4'hE, CMD_PROTECT);
    cpu.wr(PROTECT_ADDR, PROTECT_DATA, 1'b0);
    cpu.poll(a, n);
    `CHK("prot time", 1'b1, n <= 275)
    {wc, lc, pm} <= 3'b111;
    cpu.seq(4'hF, CMD_ID_ENTRY);
    cpu.rd(PROTECT_ADDR, r);
    `CHK("prot id", 1'b0, r[7:0] == PROT_OFF_BYTE)
    cpu.wr(16'hF000, CMD_ID_EXIT, 1'b0);
    `CHK("allow", 2'b00, {wal, lal})
    `CHK("par blk", 1'b1, pbl)
    cpu.rd(a, r);
    `CHK("par rd", 9'h100, r)
    pm <= 1'b0;
    chip();
    `CHK("unprot", 2'b11, {wal, lal})
    `CHK("wdog", 1'b1, wdg)
    wrap_up();
  end
endmodule
`default_nettype wire
